// ---- core/flcs_pkg.sv ----
// Purpose: Constants and types for the flash lock-clear host sequencer
// Assumes: Byte-wide flash on asynchronous pins, host runs on aclk
// Notes: Register offsets are byte addresses on AXI4-Lite
package flcs_pkg;
  localparam logic [7:0] FLCS_CMD_SETUP   = 8'h60;
  localparam logic [7:0] FLCS_CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] FLCS_CMD_ARRAY   = 8'hFF;
  localparam int FLCS_READY_BIT  = 7;
  localparam int FLCS_ERASE_BIT  = 5;
  localparam int FLCS_PROG_BIT   = 4;
  localparam int FLCS_SUPPLY_BIT = 3;
  localparam int FLCS_PROT_BIT   = 1;
  // Register byte offsets
  localparam logic [3:0] FLCS_OFF_CTRL   = 4'h0;
  localparam logic [3:0] FLCS_OFF_STAT   = 4'h4;
  localparam logic [3:0] FLCS_OFF_IRQ    = 4'h8;
  localparam logic [3:0] FLCS_OFF_IRQEN  = 4'hC;
  // Pin timing: strobe phase of 100 ns, rounded up to cycles
  localparam int FLCS_CLK_NS   = 50;
  localparam int FLCS_PHASE_NS = 100;
  localparam int FLCS_PHASE_CYC = (FLCS_PHASE_NS + FLCS_CLK_NS - 1) / FLCS_CLK_NS;
  localparam logic [3:0] FLCS_PHASE_CNT = 4'(FLCS_PHASE_CYC);
  localparam logic [2:0] FLCS_IRQ_RST = 3'h0;
  typedef enum logic [3:0] {
    FLCS_IDLE  = 4'h0,
    FLCS_WR    = 4'h1,
    FLCS_WGAP  = 4'h2,
    FLCS_WAIT  = 4'h3,
    FLCS_RD    = 4'h4,
    FLCS_RGAP  = 4'h5,
    FLCS_EVAL  = 4'h6
  } flcs_state_type;
  // Pin outputs toward the flash
  typedef struct packed {
    logic       ce_n;
    logic       we_n;
    logic       oe_n;
    logic       reset_powerdown_n;
    logic [7:0] dq_out;
    logic       dq_oe;
  } flcs_pins_type;
endpackage

// ---- core/flcs_ctrl.sv ----
// Purpose: Host sequencer that clears block lock-bits on a byte-wide flash
// Assumes: AXI4-Lite slave for software, flash pins asynchronous to aclk
// Notes: CTRL bit0 start, bit1 power-down request; STAT shows last status byte
`timescale 1ns/10ps
module flcs_ctrl
  import flcs_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [3:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Flash pins
  output flcs_pins_type    fl_pins,
  input  wire logic [7:0]  fl_dq_in,
  input  wire logic        ready_busy_n,
  // Interrupt
  output logic             irq
);
  flcs_state_type st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [1:0] step_ff, nxt_step;
  logic [7:0] stat_ff, nxt_stat;
  logic       busy_ff, nxt_busy;
  logic       pd_ff, nxt_pd;
  logic [2:0] irq_ff, nxt_irq;
  logic [2:0] irqen_ff, nxt_irqen;
  logic       bvalid_ff, nxt_bvalid;
  logic       rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [1:0] bresp_ff, nxt_bresp;
  flcs_pins_type pins_ff, nxt_pins;
  logic [7:0] dq_s1_ff, dq_s2_ff;
  logic       rb_s1_ff, rb_s2_ff;
  logic       wr_go, start, done_ev, err_ev, abort_ev;

  // Two-flop synchronisers on flash inputs
  always_ff @(posedge aclk)
  begin
    dq_s1_ff <= fl_dq_in;
    dq_s2_ff <= dq_s1_ff;
    rb_s1_ff <= ready_busy_n;
    rb_s2_ff <= rb_s1_ff;
  end

  // Write channel taken when address and data both present
  assign wr_go     = s_awvalid && s_wvalid && !bvalid_ff;
  assign s_awready = wr_go;
  assign s_wready  = wr_go;
  assign s_arready = !rvalid_ff;
  assign start     = wr_go && s_awaddr == FLCS_OFF_CTRL && s_wstrb[0] && s_wdata[0] && !busy_ff;

  // Bus registers and interrupt bits
  always_comb
  begin
    nxt_bvalid = bvalid_ff && !s_bready;
    nxt_bresp  = bresp_ff;
    nxt_rvalid = rvalid_ff && !s_rready;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    nxt_pd     = pd_ff;
    nxt_irqen  = irqen_ff;
    nxt_irq    = irq_ff;
    if (wr_go)
    begin
      nxt_bvalid = 1'b1;
      nxt_bresp  = 2'b00;
      unique case (s_awaddr)
        FLCS_OFF_CTRL:  if (s_wstrb[0]) nxt_pd = s_wdata[1];
        FLCS_OFF_IRQ:   if (s_wstrb[0]) nxt_irq = irq_ff & ~s_wdata[2:0];
        FLCS_OFF_IRQEN: if (s_wstrb[0]) nxt_irqen = s_wdata[2:0];
        FLCS_OFF_STAT:  nxt_bresp = 2'b10;
        default:        nxt_bresp = 2'b10;
      endcase
    end
    // Set wins over clear
    nxt_irq = nxt_irq | {abort_ev, err_ev, done_ev};
    if (s_arvalid && !rvalid_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = 2'b00;
      unique case (s_araddr)
        FLCS_OFF_CTRL:  nxt_rdata = {30'h0, pd_ff, busy_ff};
        FLCS_OFF_STAT:  nxt_rdata = {23'h0, !rb_s2_ff, stat_ff};
        FLCS_OFF_IRQ:   nxt_rdata = {29'h0, irq_ff};
        FLCS_OFF_IRQEN: nxt_rdata = {29'h0, irqen_ff};
        default:
        begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = 2'b10;
        end
      endcase
    end
  end

  // Pin sequencer
  always_comb
  begin
    nxt_st   = st_ff;
    nxt_cnt  = (cnt_ff != 4'h0) ? cnt_ff - 4'h1 : cnt_ff;
    nxt_step = step_ff;
    nxt_stat = stat_ff;
    nxt_busy = busy_ff;
    nxt_pins = pins_ff;
    done_ev  = 1'b0;
    err_ev   = 1'b0;
    abort_ev = 1'b0;
    nxt_pins.reset_powerdown_n = !pd_ff;
    unique case (st_ff)
      FLCS_IDLE:
        if (start && !pd_ff)
        begin
          nxt_busy = 1'b1;
          nxt_step = 2'h0;
          nxt_st   = FLCS_WR;
          nxt_cnt  = FLCS_PHASE_CNT;
          nxt_pins.dq_out = FLCS_CMD_SETUP;
          nxt_pins.dq_oe  = 1'b1;
          nxt_pins.ce_n   = 1'b0;
          nxt_pins.we_n   = 1'b0;
        end
      FLCS_WR:
        if (cnt_ff == 4'h0)
        begin
          nxt_pins.we_n = 1'b1;
          nxt_pins.ce_n = 1'b1;
          nxt_st  = FLCS_WGAP;
          nxt_cnt = FLCS_PHASE_CNT;
        end
      FLCS_WGAP:
        if (cnt_ff == 4'h0)
        begin
          nxt_pins.dq_oe = 1'b0;
          if (step_ff == 2'h0)
          begin
            nxt_step = 2'h1;
            nxt_st   = FLCS_WR;
            nxt_cnt  = FLCS_PHASE_CNT;
            nxt_pins.dq_out = FLCS_CMD_CONFIRM;
            nxt_pins.dq_oe  = 1'b1;
            nxt_pins.ce_n   = 1'b0;
            nxt_pins.we_n   = 1'b0;
          end
          else if (step_ff == 2'h1)
          begin
            nxt_st  = FLCS_RD;
            nxt_cnt = FLCS_PHASE_CNT;
            nxt_pins.ce_n = 1'b0; // Reads give status now
            nxt_pins.oe_n = 1'b0;
          end
          else
          begin
            nxt_busy = 1'b0;
            nxt_st   = FLCS_IDLE;
            done_ev  = 1'b1;
          end
        end
      FLCS_RD:
        if (cnt_ff == 4'h0)
        begin
          nxt_stat = dq_s2_ff;
          nxt_pins.ce_n = 1'b1;
          nxt_pins.oe_n = 1'b1;
          nxt_st  = FLCS_RGAP;
          nxt_cnt = FLCS_PHASE_CNT;
        end
      FLCS_RGAP:
        if (cnt_ff == 4'h0)
        begin
          if (stat_ff[FLCS_READY_BIT] && rb_s2_ff)
            nxt_st = FLCS_EVAL;
          else
          begin
            nxt_st  = FLCS_RD;
            nxt_cnt = FLCS_PHASE_CNT;
            nxt_pins.ce_n = 1'b0;
            nxt_pins.oe_n = 1'b0;
          end
        end
      FLCS_EVAL:
      begin
        // Any of supply, protect, sequence or clear errors
        err_ev = stat_ff[FLCS_SUPPLY_BIT] | stat_ff[FLCS_PROT_BIT] | stat_ff[FLCS_ERASE_BIT]
               | stat_ff[FLCS_PROG_BIT];
        nxt_step = 2'h2;
        nxt_st   = FLCS_WR;
        nxt_cnt  = FLCS_PHASE_CNT;
        nxt_pins.dq_out = FLCS_CMD_ARRAY;
        nxt_pins.dq_oe  = 1'b1;
        nxt_pins.ce_n   = 1'b0;
        nxt_pins.we_n   = 1'b0;
      end
      default: nxt_st = FLCS_IDLE;
    endcase
    // Power-down mid-sequence aborts; software must restart
    if (pd_ff && st_ff != FLCS_IDLE)
    begin
      nxt_st   = FLCS_IDLE;
      nxt_busy = 1'b0;
      abort_ev = 1'b1;
      nxt_pins.ce_n  = 1'b1;
      nxt_pins.we_n  = 1'b1;
      nxt_pins.oe_n  = 1'b1;
      nxt_pins.dq_oe = 1'b0;
    end
  end

  // Register stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff     <= FLCS_IDLE;
      cnt_ff    <= 4'h0;
      step_ff   <= 2'h0;
      stat_ff   <= 8'h00;
      busy_ff   <= 1'b0;
      pd_ff     <= 1'b0;
      irq_ff    <= FLCS_IRQ_RST;
      irqen_ff  <= FLCS_IRQ_RST;
      bvalid_ff <= 1'b0;
      bresp_ff  <= 2'b00;
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= 2'b00;
      pins_ff   <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, reset_powerdown_n: 1'b1,
                     dq_out: 8'h00, dq_oe: 1'b0};
    end
    else
    begin
      st_ff     <= nxt_st;
      cnt_ff    <= nxt_cnt;
      step_ff   <= nxt_step;
      stat_ff   <= nxt_stat;
      busy_ff   <= nxt_busy;
      pd_ff     <= nxt_pd;
      irq_ff    <= nxt_irq;
      irqen_ff  <= nxt_irqen;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
      pins_ff   <= nxt_pins;
    end
  end

  // Outputs
  assign s_bvalid = bvalid_ff;
  assign s_bresp  = bresp_ff;
  assign s_rvalid = rvalid_ff;
  assign s_rdata  = rdata_ff;
  assign s_rresp  = rresp_ff;
  assign fl_pins  = pins_ff;
  assign irq      = |(irq_ff & irqen_ff);
endmodule

// ---- sim/flcs_ctrl_asserts.sv ----
// Purpose: Pin checks for the lock-clear host
// Assumes: Pins registered on aclk
// Notes: Bound below
`timescale 1ns/10ps
module flcs_ctrl_asserts
  import flcs_pkg::*;
(
  // Clock and reset
  input wire logic          aclk,
  input wire logic          aresetn,
  // Flash side
  input wire flcs_pins_type fl_pins,
  input wire logic          ready_busy_n,
  input wire logic          irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Short names
  logic [7:0] d;
  logic       rp;
  logic       wf;
  assign d = fl_pins.dq_out;
  assign rp = fl_pins.reset_powerdown_n;
  assign wf = !fl_pins.we_n;
  // Command order on the pins
  chk_confirm_next:
    assert property ($rose(wf) && d == FLCS_CMD_SETUP |-> ##[1:12]
      ($rose(wf) && d == FLCS_CMD_CONFIRM || !rp)) else $error("no confirm");
  chk_ready_first:
    assert property ($rose(wf) && d == FLCS_CMD_ARRAY |->
      ready_busy_n && $past(ready_busy_n, 2)) else $error("array while busy");
  chk_array_return:
    assert property ($rose(wf) && d == FLCS_CMD_CONFIRM |-> ##[4:400]
      ($rose(wf) && d == FLCS_CMD_ARRAY || !rp)) else $error("no array");
  chk_pd_quiet:
    assert property (!rp |-> !wf && fl_pins.ce_n) else $error("write in pd");
  // Data lines driven through every write strobe, released through every read
  chk_write_drive:
    assert property (wf |-> !fl_pins.ce_n && fl_pins.dq_oe)
      else $error("write strobe without data drive");
  chk_read_release:
    assert property (!fl_pins.oe_n |-> !fl_pins.dq_oe && fl_pins.we_n)
      else $error("read enable while driving data");
  // Main scenarios
  cover property ($rose(irq));
  cover property ($fell(rp));
  cover property ($rose(wf) && d == FLCS_CMD_ARRAY);
endmodule
bind flcs_ctrl flcs_ctrl_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .fl_pins(fl_pins),
  .ready_busy_n(ready_busy_n), .irq(irq));

// ---- sim/flcs_flash_model.sv ----
// Purpose: Flash model
// Assumes: Fixed busy time
// Notes: Idle data toggles
`timescale 1ns/10ps
module flcs_flash_model
  import flcs_pkg::*;
(
  // Host side
  input  wire flcs_pins_type pins,
  input  wire logic [7:0]    err_bits,
  // Device side
  output logic [7:0]         dq,
  output logic               ready_busy_n
);
  localparam int BUSY_CYC = 30;
  logic [7:0] cmd, stat, idle;
  logic       pend, setup, show;
  int         left;
  // Power-up in read-array mode
  initial
  begin
    {pend, setup, show, left} = '0;
    stat = 8'h80;
    idle = 8'h5a;
    ready_busy_n = 1'b1;
  end
  // Latch a byte while written, act when the strobe ends
  always @(pins)
    if (!pins.we_n && !pins.ce_n && pins.reset_powerdown_n)
    begin
      cmd = pins.dq_out;
      pend = 1'b1;
    end
    else if (pend)
    begin
      pend = 1'b0;
      show = cmd != FLCS_CMD_ARRAY;
      if (setup && cmd == FLCS_CMD_CONFIRM)
      begin
        left = BUSY_CYC;
        stat = 8'h00;
        ready_busy_n = 1'b0;
      end
      setup = cmd == FLCS_CMD_SETUP;
    end
  // Algorithm timer; result carries the injected error bits
  always #50
  begin
    idle = ~idle;
    if (left == 1)
    begin
      stat = 8'h80 | err_bits;
      ready_busy_n = 1'b1;
    end
    if (left > 0)
      left--;
  end
  // Power-down drops setup and status mode
  always @(negedge pins.reset_powerdown_n)
    {setup, show} = 2'b00;
  // Drive read data while selected and read-enabled, the toggling idle byte otherwise
  assign dq = !pins.ce_n && !pins.oe_n && pins.reset_powerdown_n ?
              (show ? stat : 8'h3c) : idle;
endmodule

// ---- sim/flcs_ctrl_tb.sv ----
// Purpose: Bench for the lock-clear host
// Assumes: Model busy 30 cycles
// Notes: Requests held until taken
`timescale 1ns/10ps
module flcs_ctrl_tb
  import flcs_pkg::*;
;
  localparam logic [31:0] SEQ = {8'h03, FLCS_CMD_SETUP, FLCS_CMD_CONFIRM, FLCS_CMD_ARRAY};
  logic          aclk, aresetn, aw_v, w_v, b_r, ar_v, r_r, we_d;
  logic          aw_r, w_r, b_v, ar_r, r_v, irq, rbn;
  logic [3:0]    aw_a, ar_a;
  logic [31:0]   w_d, r_d, rd;
  logic [1:0]    b_s, r_s, rsp;
  logic [7:0]    dq, err_bits;
  flcs_pins_type pins;
  int            err_total, check_count, cyc;
  logic [7:0]    cmd_q[$];
  flcs_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_awaddr(aw_a), .s_awvalid(aw_v),
    .s_awready(aw_r), .s_wdata(w_d), .s_wstrb(4'hf), .s_wvalid(w_v), .s_wready(w_r),
    .s_bresp(b_s), .s_bvalid(b_v), .s_bready(b_r), .s_araddr(ar_a), .s_arvalid(ar_v),
    .s_arready(ar_r), .s_rdata(r_d), .s_rresp(r_s), .s_rvalid(r_v), .s_rready(r_r),
    .fl_pins(pins), .fl_dq_in(dq), .ready_busy_n(rbn), .irq(irq));
  flcs_flash_model u_fl (.pins(pins), .err_bits(err_bits), .dq(dq), .ready_busy_n(rbn));
  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Log each command byte; cut a hang short
  always @(posedge aclk)
  begin
    we_d <= pins.we_n;
    if (we_d && !pins.we_n)
      cmd_q.push_back(pins.dq_out);
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // One write, held until taken, then the response; bready stays high all run
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    {aw_a, w_d, aw_v, w_v} <= {a, d, 2'b11};
    do @(posedge aclk); while (aw_r !== 1'b1);
    {aw_v, w_v} <= 2'b00;
    do @(posedge aclk); while (b_v !== 1'b1);
    rsp = b_s;
  endtask
  // One read; rready stays high all run
  task automatic rdr(input logic [3:0] a);
    {ar_a, ar_v} <= {a, 1'b1};
    do @(posedge aclk); while (ar_r !== 1'b1);
    ar_v <= 1'b0;
    do @(posedge aclk); while (r_v !== 1'b1);
    {rd, rsp} = {r_d, r_s};
  endtask
  // Start a clear and wait till idle
  task automatic run(input logic [7:0] code);
    err_bits <= code;
    cmd_q.delete();
    wr(FLCS_OFF_CTRL, 32'h1);
    do rdr(FLCS_OFF_CTRL); while (rd[0] !== 1'b0);
    chk({8'(cmd_q.size()), cmd_q[0], cmd_q[1], cmd_q[2]}, SEQ);
  endtask
  // Reset value, refused status write, enable read-back
  task automatic t_regs();
    rdr(FLCS_OFF_IRQEN);
    chk(rd & 32'h7, {29'h0, FLCS_IRQ_RST});
    rdr(4'h2);
    chk(32'(rsp), 32'h2);
    wr(FLCS_OFF_STAT, 32'h00ff);
    chk(32'(rsp), 32'h2);
    wr(FLCS_OFF_IRQEN, 32'h7);
    rdr(FLCS_OFF_IRQEN);
    chk(rd & 32'h7, 32'h7);
  endtask
  // Clean run, then each error code
  task automatic t_codes();
    logic [7:0] codes[5] = '{8'h00, 8'h20, 8'h30, 8'h28, 8'h02};
    foreach (codes[i])
    begin
      run(codes[i]);
      rdr(FLCS_OFF_STAT);
      chk(rd & 32'h00ff, 32'h80 | codes[i]);
      rdr(FLCS_OFF_IRQ);
      chk(rd & 32'h2, {30'h0, codes[i] != 0, 1'b0});
      chk(32'(irq), 32'h1);
      wr(FLCS_OFF_IRQ, 32'h7);
      chk(32'(irq), 32'h0);
    end
  endtask
  // Masked power-down abort mid-operation, then a full rerun
  task automatic t_abort();
    wr(FLCS_OFF_IRQEN, 32'h0);
    err_bits <= 8'h00;
    wr(FLCS_OFF_CTRL, 32'h1);
    while (rbn !== 1'b0) @(posedge aclk);
    wr(FLCS_OFF_CTRL, 32'h2);
    // Pin follows the power-down bit one edge after the response
    @(posedge aclk);
    chk(32'({pins.reset_powerdown_n, rbn}), 32'h0);
    rdr(FLCS_OFF_STAT);
    chk(32'(rd[8]), 32'h1);
    while (rbn !== 1'b1) @(posedge aclk);
    rdr(FLCS_OFF_IRQ);
    chk(32'({irq, rd[2]}), 32'h1);
    wr(FLCS_OFF_IRQ, 32'h7);
    wr(FLCS_OFF_IRQEN, 32'h7);
    wr(FLCS_OFF_CTRL, 32'h0);
    run(8'h00);
  endtask
  // Main sequence
  initial
  begin
    {aresetn, aw_v, w_v, b_r, ar_v, r_r, aw_a, ar_a, w_d, err_bits} = '0;
    {err_total, check_count, cyc, we_d} = '1;
    {err_total, check_count, cyc} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    {b_r, r_r} <= 2'b11;
    @(posedge aclk);
    t_regs();
    t_codes();
    t_abort();
    give_verdict();
  end
endmodule
